//--- qst_consts.svh
`ifndef QST_CONSTS_SVH
`define QST_CONSTS_SVH

// ----------------------------------------------------------------
// Questionable flag layout
// ----------------------------------------------------------------
`define QST_FLAG_W          12
`define QST_VOLTAGE_ERR_BIT 0
`define QST_CURRENT_ERR_BIT 1
`define QST_OVERTEMP_BIT    3
`define QST_RELAY_ERR_BIT   9
`define QST_OVERLOAD_BIT    10
`define QST_POWER_LOSS_BIT  11
`define QST_USED_MASK       12'he0b
`define QST_FLAG_RESET      12'h000

// ----------------------------------------------------------------
// Channel summary layout
// ----------------------------------------------------------------
`define QST_SUM_W           16
`define QST_NUM_CHAN        31
`define QST_CHAN_SEL_W      5
`define QST_LOW_FIRST_CHAN  1
`define QST_MID_FIRST_CHAN  15
`define QST_HIGH_FIRST_CHAN 29
`define QST_LOW_LAST_BIT    14
`define QST_HIGH_LAST_BIT   3
`define QST_CASCADE_BIT     0
`define QST_LOW_MASK_USED   16'h7fff
`define QST_HIGH_MASK_USED  16'h000e
`define QST_SUM_RESET       16'h0000

`endif

//--- qst_pkg.sv
package qst_pkg;

  // ----------------------------------------------------------------
  // Register selection codes of the host command port
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    QST_SEL_EVENT,
    QST_SEL_COND,
    QST_SEL_ENABLE,
    QST_SEL_SUM_LOW,
    QST_SEL_SUM_MID,
    QST_SEL_SUM_HIGH,
    QST_SEL_MASK_LOW,
    QST_SEL_MASK_MID,
    QST_SEL_MASK_HIGH,
    QST_SEL_PER_CHAN
  } qst_sel_t;

endpackage

//--- qst_evt_latch.sv
`include "qst_consts.svh"

module qst_evt_latch (
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_rst,
  input  wire logic [`QST_FLAG_W-1:0] i_cond,
  input  wire logic [`QST_FLAG_W-1:0] i_mask,
  input  wire logic                   i_clear,
  output logic      [`QST_FLAG_W-1:0] o_event,
  output logic                        o_set_any
);

  logic [`QST_FLAG_W-1:0] cond_prev_reg;
  logic [`QST_FLAG_W-1:0] event_reg;
  logic [`QST_FLAG_W-1:0] set_vec;

  // ----------------------------------------------------------------
  // Edge capture
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      cond_prev_reg <= `QST_FLAG_RESET;
    else
      cond_prev_reg <= i_cond;
  end

  // A flag is caught on its rising edge, so a condition that stays on
  // does not keep refilling the latch after every read.
  assign set_vec   = i_cond & ~cond_prev_reg & i_mask;
  assign o_set_any = |set_vec;

  // ----------------------------------------------------------------
  // Latch, cleared by a read; a new event in the read cycle survives
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      event_reg <= `QST_FLAG_RESET;
    else if (i_clear)
      event_reg <= set_vec;
    else
      event_reg <= event_reg | set_vec;
  end

  assign o_event = event_reg;

endmodule // qst_evt_latch

//--- qst_status_tree.sv
// Contract
// - Flags at bits 0,1,3,9,10,11; others unused.
// - Enable mask selects flags reaching event latch.
// - Status bit 3 is OR of enabled events.
// - Enable mask reads back last write, used flag bits only.
// - Low summary: channels 1-14, bit0 mid cascade.
// - Channel bit sets on enabled channel event.
// - Reading low summary clears bits 1-14.
// - Low bit0 persists until mid summary read.
// - Mid summary: channels 15-28, bit0 high cascade.
// - Mid read clears 1-14; bit0 until high read.
// - High summary: channels 29-31 at bits 1-3.
// - Reading high summary clears its channel bits.
// - Low channel mask gates low summary bits.
// - Mid channel mask gates mid summary bits.
// - High channel mask gates high summary bits.
// - All channel masks read back as written in used bits only.
// - Per-channel copy; read returns selected channel.
// - Event latch read-only, cleared after read.
// - Condition register shows live flags.
`include "qst_consts.svh"

module qst_status_tree (
  input  wire logic                                 i_clk_sys,
  input  wire logic                                 i_rst,
  input  wire logic [`QST_FLAG_W-1:0]               i_ques_cond,
  input  wire logic [`QST_NUM_CHAN*`QST_FLAG_W-1:0] i_chan_cond,
  input  wire logic [`QST_CHAN_SEL_W-1:0]           i_chan_sel,
  input  wire logic                                 i_rd_req,
  input  wire logic                                 i_wr_req,
  input  wire qst_pkg::qst_sel_t                    i_reg_sel,
  input  wire logic [`QST_SUM_W-1:0]                i_wr_data,
  output logic      [`QST_SUM_W-1:0]                o_rd_data,
  output logic                                      o_rd_valid,
  output logic                                      o_ques_summary
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [`QST_FLAG_W-1:0] cond_live;
  logic [`QST_FLAG_W-1:0] enable_reg;
  logic [`QST_FLAG_W-1:0] ques_evt;
  logic [`QST_FLAG_W-1:0] chan_evt [1:`QST_NUM_CHAN];
  logic [`QST_NUM_CHAN:1] chan_new;
  logic [`QST_SUM_W-1:0]  mask_low_reg;
  logic [`QST_SUM_W-1:0]  mask_mid_reg;
  logic [`QST_SUM_W-1:0]  mask_high_reg;
  logic [`QST_SUM_W-1:0]  sum_low_reg;
  logic [`QST_SUM_W-1:0]  sum_mid_reg;
  logic [`QST_SUM_W-1:0]  sum_high_reg;
  logic [`QST_SUM_W-1:0]  low_set;
  logic [`QST_SUM_W-1:0]  mid_set;
  logic [`QST_SUM_W-1:0]  high_set;
  logic [`QST_SUM_W-1:0]  rd_next;
  logic                   mid_new;
  logic                   high_new;
  logic                   rd_event;
  logic                   rd_low;
  logic                   rd_mid;
  logic                   rd_high;
  logic                   rd_chan;
  logic                   chan_valid;

  // ----------------------------------------------------------------
  // Read strobes
  // ----------------------------------------------------------------
  assign rd_event   = i_rd_req && (i_reg_sel == qst_pkg::QST_SEL_EVENT);
  assign rd_low     = i_rd_req && (i_reg_sel == qst_pkg::QST_SEL_SUM_LOW);
  assign rd_mid     = i_rd_req && (i_reg_sel == qst_pkg::QST_SEL_SUM_MID);
  assign rd_high    = i_rd_req && (i_reg_sel == qst_pkg::QST_SEL_SUM_HIGH);
  assign rd_chan    = i_rd_req && (i_reg_sel == qst_pkg::QST_SEL_PER_CHAN);
  assign chan_valid = (i_chan_sel != 5'h00);

  // Unused positions are forced low so they can never latch.
  assign cond_live = i_ques_cond & `QST_USED_MASK;

  // ----------------------------------------------------------------
  // Unit event latch
  // ----------------------------------------------------------------
  qst_evt_latch u_unit_latch (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_cond    (cond_live),
    .i_mask    (enable_reg),
    .i_clear   (rd_event),
    .o_event   (ques_evt),
    .o_set_any ()
  );

  // ----------------------------------------------------------------
  // Per-channel latches
  // ----------------------------------------------------------------
  // Every channel shares the unit enable mask; a separate mask per
  // channel would cost 31 more registers for little reporting gain.
  generate
    for (genvar c = 1; c <= `QST_NUM_CHAN; c++)
    begin : g_chan
      qst_evt_latch u_chan_latch (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_cond    (i_chan_cond[(c-1)*`QST_FLAG_W +: `QST_FLAG_W] & `QST_USED_MASK),
        .i_mask    (enable_reg),
        .i_clear   (rd_chan && (i_chan_sel == 5'(c))),
        .o_event   (chan_evt[c]),
        .o_set_any (chan_new[c])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Enable and channel mask registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      enable_reg <= `QST_FLAG_RESET;
    else if (i_wr_req && (i_reg_sel == qst_pkg::QST_SEL_ENABLE))
      enable_reg <= i_wr_data[`QST_FLAG_W-1:0] & `QST_USED_MASK;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      mask_low_reg <= `QST_SUM_RESET;
    else if (i_wr_req && (i_reg_sel == qst_pkg::QST_SEL_MASK_LOW))
      mask_low_reg <= i_wr_data & `QST_LOW_MASK_USED;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      mask_mid_reg <= `QST_SUM_RESET;
    else if (i_wr_req && (i_reg_sel == qst_pkg::QST_SEL_MASK_MID))
      mask_mid_reg <= i_wr_data & `QST_LOW_MASK_USED;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      mask_high_reg <= `QST_SUM_RESET;
    else if (i_wr_req && (i_reg_sel == qst_pkg::QST_SEL_MASK_HIGH))
      mask_high_reg <= i_wr_data & `QST_HIGH_MASK_USED;
  end

  // ----------------------------------------------------------------
  // Channel set vectors
  // ----------------------------------------------------------------
  always_comb
  begin
    low_set  = `QST_SUM_RESET;
    mid_set  = `QST_SUM_RESET;
    high_set = `QST_SUM_RESET;
    for (int b = 1; b <= `QST_LOW_LAST_BIT; b++)
    begin
      low_set[b] = chan_new[b] & mask_low_reg[b];
      mid_set[b] = chan_new[b+`QST_MID_FIRST_CHAN-1] & mask_mid_reg[b];
    end
    for (int b = 1; b <= `QST_HIGH_LAST_BIT; b++)
    begin
      high_set[b] = chan_new[b+`QST_HIGH_FIRST_CHAN-1] & mask_high_reg[b];
    end
  end

  assign high_new = |high_set;
  assign mid_new  = (|mid_set) | high_new;

  // ----------------------------------------------------------------
  // Low summary
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      sum_low_reg <= `QST_SUM_RESET;
    else
    begin
      if (rd_low)
        sum_low_reg[14:1] <= low_set[14:1];
      else
        sum_low_reg[14:1] <= sum_low_reg[14:1] | low_set[14:1];
      if (mid_new)
        sum_low_reg[`QST_CASCADE_BIT] <= 1'b1;
      else if (rd_mid)
        sum_low_reg[`QST_CASCADE_BIT] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Mid summary
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      sum_mid_reg <= `QST_SUM_RESET;
    else
    begin
      if (rd_mid)
        sum_mid_reg[14:1] <= mid_set[14:1];
      else
        sum_mid_reg[14:1] <= sum_mid_reg[14:1] | mid_set[14:1];
      if (high_new)
        sum_mid_reg[`QST_CASCADE_BIT] <= 1'b1;
      else if (rd_high)
        sum_mid_reg[`QST_CASCADE_BIT] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // High summary
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      sum_high_reg <= `QST_SUM_RESET;
    else if (rd_high)
      sum_high_reg <= high_set;
    else
      sum_high_reg <= sum_high_reg | high_set;
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_next = `QST_SUM_RESET;
    unique case (i_reg_sel)
      qst_pkg::QST_SEL_EVENT:     rd_next[11:0] = ques_evt;
      qst_pkg::QST_SEL_COND:      rd_next[11:0] = cond_live;
      qst_pkg::QST_SEL_ENABLE:    rd_next[11:0] = enable_reg;
      qst_pkg::QST_SEL_SUM_LOW:   rd_next = sum_low_reg;
      qst_pkg::QST_SEL_SUM_MID:   rd_next = sum_mid_reg;
      qst_pkg::QST_SEL_SUM_HIGH:  rd_next = sum_high_reg;
      qst_pkg::QST_SEL_MASK_LOW:  rd_next = mask_low_reg;
      qst_pkg::QST_SEL_MASK_MID:  rd_next = mask_mid_reg;
      qst_pkg::QST_SEL_MASK_HIGH: rd_next = mask_high_reg;
      qst_pkg::QST_SEL_PER_CHAN:
        if (chan_valid)
          rd_next[11:0] = chan_evt[i_chan_sel];
      default:                    rd_next = `QST_SUM_RESET;
    endcase
  end

  // The value is captured on the same edge that clears the source, so
  // the host always sees the contents from before its own read.
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      o_rd_data <= `QST_SUM_RESET;
    else if (i_rd_req)
      o_rd_data <= rd_next;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      o_rd_valid <= 1'b0;
    else
      o_rd_valid <= i_rd_req;
  end

  // ----------------------------------------------------------------
  // Status byte summary
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      o_ques_summary <= 1'b0;
    else
      o_ques_summary <= |(ques_evt & enable_reg);
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  summary_flag_a: assert property (
    ##1 o_ques_summary == $past(|(ques_evt & enable_reg)))
    else $error("summary flag differs from enabled events");

  event_set_a: assert property (
    (cond_live[1] && !$past(cond_live[1]) && enable_reg[1])
      |=> ques_evt[1])
    else $error("enabled rising flag not latched");

  event_hold_a: assert property (
    (ques_evt[0] && !rd_event) |=> ques_evt[0])
    else $error("event bit dropped without a read");

  event_clear_a: assert property (
    (rd_event && !(cond_live[0] && enable_reg[0])) |=> !ques_evt[0])
    else $error("event bit not cleared by read");

  enable_read_a: assert property (
    (i_wr_req && i_reg_sel == qst_pkg::QST_SEL_ENABLE) ##1 !i_wr_req
      ##1 (i_rd_req && !i_wr_req && i_reg_sel == qst_pkg::QST_SEL_ENABLE)
      |=> o_rd_data[11:0] == ($past(i_wr_data[11:0], 3) & `QST_USED_MASK))
    else $error("enable mask readback wrong");

  low_clear_a: assert property (
    (rd_low && low_set == 16'h0000) |=> sum_low_reg[14:1] == 14'h0000)
    else $error("low summary not cleared by read");

  cascade_keep_a: assert property (
    (sum_low_reg[0] && !rd_mid) |=> sum_low_reg[0])
    else $error("low cascade bit lost early");

  cascade_clear_a: assert property (
    (rd_high && !high_new) |=> !sum_mid_reg[0])
    else $error("mid cascade bit not cleared by high read");

  high_unused_a: assert property (
    sum_high_reg[15:4] == 12'h000 && !sum_high_reg[0])
    else $error("unused high summary bit set");

  mask_gate_a: assert property (
    (!mask_low_reg[1] && rd_low) |=> !sum_low_reg[1])
    else $error("masked channel reached low summary");

  mid_clear_a: assert property (
    (rd_mid && mid_set == 16'h0000) |=> sum_mid_reg[14:1] == 14'h0000)
    else $error("mid summary not cleared by read");

  high_clear_a: assert property (
    (rd_high && high_set == 16'h0000) |=> sum_high_reg == 16'h0000)
    else $error("high summary not cleared by read");

  cascade_set_a: assert property (
    mid_new |=> sum_low_reg[0])
    else $error("low cascade bit not set");

  mid_cascade_a: assert property (
    high_new |=> sum_mid_reg[0])
    else $error("mid cascade bit not set");

  unused_flags_a: assert property (
    ques_evt[8:4] == 5'h00 && !ques_evt[2])
    else $error("unused event bit set");

  read_valid_a: assert property (
    i_rd_req |=> o_rd_valid ##1 (o_rd_valid == $past(i_rd_req)))
    else $error("read answer timing wrong");

  summary_rise_c: cover property (!o_ques_summary ##1 o_ques_summary);
  cascade_c:      cover property (high_new ##1 sum_mid_reg[0] ##[1:8] rd_high);
  chan_read_c:    cover property (rd_chan && chan_valid && rd_next != 16'h0000);
  high_read_c:    cover property (rd_high && sum_high_reg != 16'h0000);
  gate_block_c:   cover property (chan_new[1] && !mask_low_reg[1]);

endmodule // qst_status_tree

//--- qst_host_model.sv
// --------
// Host side of the status command port.
// --------
module qst_host_model (
  input  wire logic         i_clk_sys,
  input  wire logic [15:0]  i_rd_data,
  input  wire logic         i_rd_valid,
  output qst_pkg::qst_sel_t o_reg_sel,
  output logic              o_rd_req,
  output logic              o_wr_req,
  output logic      [15:0]  o_wr_data,
  output logic      [4:0]   o_chan_sel
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    o_reg_sel = qst_pkg::QST_SEL_EVENT;
    o_rd_req = 1'b0;
    o_wr_req = 1'b0;
    o_wr_data = 16'h0000;
    o_chan_sel = 5'h00;
  end

  task automatic write_reg(input qst_pkg::qst_sel_t sel, input logic [15:0] data);
    @(posedge i_clk_sys);
    o_wr_req <= 1'b1;
    o_reg_sel <= sel;
    o_wr_data <= data;
    @(posedge i_clk_sys);
    o_wr_req <= 1'b0;
    // Stale data is inverted so a late sample cannot pass by luck.
    o_wr_data <= ~data;
  endtask

  task automatic read_reg(input qst_pkg::qst_sel_t sel, output logic [15:0] data);
    int n;
    @(posedge i_clk_sys);
    o_rd_req <= 1'b1;
    o_reg_sel <= sel;
    @(posedge i_clk_sys);
    o_rd_req <= 1'b0;
    n = 0;
    #1;
    while (i_rd_valid !== 1'b1 && n < 4)
    begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
    data = (i_rd_valid === 1'b1) ? i_rd_data : 16'hxxxx;
  endtask

  task automatic read_chan(input logic [4:0] chan, output logic [15:0] data);
    @(posedge i_clk_sys);
    o_chan_sel <= chan;
    read_reg(qst_pkg::QST_SEL_PER_CHAN, data);
  endtask
endmodule // qst_host_model

//--- qst_status_tree_bench.sv
`include "qst_consts.svh"

// --------
// Bench for the status tree.
// --------
module qst_status_tree_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk;
  logic              rst;
  logic [11:0]       ques_cond;
  logic [371:0]      chan_cond;
  logic              rd_req;
  logic              wr_req;
  qst_pkg::qst_sel_t sel;
  logic [15:0]       wr_data;
  logic [4:0]        chan_sel;
  logic [15:0]       rd_data;
  logic              rd_valid;
  logic              ques_summary;
  int                errors;
  int                checks;

  qst_status_tree qst_status_tree_inst (
    .i_clk_sys      (clk),
    .i_rst          (rst),
    .i_ques_cond    (ques_cond),
    .i_chan_cond    (chan_cond),
    .i_chan_sel     (chan_sel),
    .i_rd_req       (rd_req),
    .i_wr_req       (wr_req),
    .i_reg_sel      (sel),
    .i_wr_data      (wr_data),
    .o_rd_data      (rd_data),
    .o_rd_valid     (rd_valid),
    .o_ques_summary (ques_summary)
  );

  qst_host_model qst_host_model_inst (
    .i_clk_sys  (clk),
    .i_rd_data  (rd_data),
    .i_rd_valid (rd_valid),
    .o_reg_sel  (sel),
    .o_rd_req   (rd_req),
    .o_wr_req   (wr_req),
    .o_wr_data  (wr_data),
    .o_chan_sel (chan_sel)
  );

  task automatic stop_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input qst_pkg::qst_sel_t s, input logic [15:0] d);
    qst_host_model_inst.write_reg(s, d);
  endtask

  task automatic rd(input qst_pkg::qst_sel_t s, input logic [15:0] exp);
    logic [15:0] d;
    qst_host_model_inst.read_reg(s, d);
    check(d, exp);
  endtask

  task automatic rdc(input logic [4:0] c, input logic [15:0] exp);
    logic [15:0] d;
    qst_host_model_inst.read_chan(c, d);
    check(d, exp);
  endtask

  // A condition must fall again, or the next use of it would not be a new event.
  task automatic pulse_chan(input int c, input int b);
    @(posedge clk);
    chan_cond[(c-1)*12+b] <= 1'b1;
    repeat (3) @(posedge clk);
    chan_cond[(c-1)*12+b] <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic t_reset;
    for (int s = 0; s < 16; s++)
      rd(qst_pkg::qst_sel_t'(4'(s)), 16'h0000);
  endtask

  task automatic t_masks;
    wr(qst_pkg::QST_SEL_EVENT, 16'hffff);
    rd(qst_pkg::QST_SEL_EVENT, 16'h0000);
    wr(qst_pkg::QST_SEL_COND, 16'hffff);
    rd(qst_pkg::QST_SEL_COND, 16'h0000);
    wr(qst_pkg::QST_SEL_ENABLE, 16'hffff);
    rd(qst_pkg::QST_SEL_ENABLE, 16'h0e0b);
    wr(qst_pkg::QST_SEL_MASK_LOW, 16'hffff);
    rd(qst_pkg::QST_SEL_MASK_LOW, 16'h7fff);
    wr(qst_pkg::QST_SEL_MASK_MID, 16'hffff);
    rd(qst_pkg::QST_SEL_MASK_MID, 16'h7fff);
    wr(qst_pkg::QST_SEL_MASK_HIGH, 16'hffff);
    rd(qst_pkg::QST_SEL_MASK_HIGH, 16'h000e);
  endtask

  task automatic t_events;
    @(posedge clk);
    ques_cond <= 12'hfff;
    repeat (3) @(posedge clk);
    #1;
    check({15'h0000, ques_summary}, 16'h0001);
    rd(qst_pkg::QST_SEL_COND, 16'h0e0b);
    rd(qst_pkg::QST_SEL_EVENT, 16'h0e0b);
    rd(qst_pkg::QST_SEL_EVENT, 16'h0000);
    repeat (2) @(posedge clk);
    #1;
    check({15'h0000, ques_summary}, 16'h0000);
    @(posedge clk);
    ques_cond <= 12'h000;
    wr(qst_pkg::QST_SEL_ENABLE, 16'h0001);
    @(posedge clk);
    ques_cond <= 12'h009;
    repeat (3) @(posedge clk);
    ques_cond <= 12'h000;
    repeat (3) @(posedge clk);
    rd(qst_pkg::QST_SEL_EVENT, 16'h0001);
    rd(qst_pkg::QST_SEL_COND, 16'h0000);
  endtask

  task automatic t_map;
    int ch[6] = '{1, 14, 15, 28, 29, 31};
    logic [15:0] d;
    wr(qst_pkg::QST_SEL_ENABLE, 16'h0e0b);
    foreach (ch[i])
    begin
      pulse_chan(ch[i], 0);
      if (ch[i] <= 14)
        rd(qst_pkg::QST_SEL_SUM_LOW, 16'h0001 << ch[i]);
      else if (ch[i] <= 28)
        rd(qst_pkg::QST_SEL_SUM_MID, 16'h0001 << (ch[i] - 14));
      else
        rd(qst_pkg::QST_SEL_SUM_HIGH, 16'h0001 << (ch[i] - 28));
      qst_host_model_inst.read_reg(qst_pkg::QST_SEL_SUM_HIGH, d);
      qst_host_model_inst.read_reg(qst_pkg::QST_SEL_SUM_MID, d);
      qst_host_model_inst.read_reg(qst_pkg::QST_SEL_SUM_LOW, d);
    end
  endtask

  task automatic t_cascade;
    pulse_chan(3, 1);
    rd(qst_pkg::QST_SEL_SUM_LOW, 16'h0008);
    rd(qst_pkg::QST_SEL_SUM_LOW, 16'h0000);
    pulse_chan(20, 9);
    rd(qst_pkg::QST_SEL_SUM_LOW, 16'h0001);
    rd(qst_pkg::QST_SEL_SUM_LOW, 16'h0001);
    rd(qst_pkg::QST_SEL_SUM_MID, 16'h0040);
    rd(qst_pkg::QST_SEL_SUM_LOW, 16'h0000);
    pulse_chan(30, 11);
    rd(qst_pkg::QST_SEL_SUM_MID, 16'h0001);
    rd(qst_pkg::QST_SEL_SUM_MID, 16'h0001);
    rd(qst_pkg::QST_SEL_SUM_HIGH, 16'h0004);
    rd(qst_pkg::QST_SEL_SUM_HIGH, 16'h0000);
    rd(qst_pkg::QST_SEL_SUM_MID, 16'h0000);
    rd(qst_pkg::QST_SEL_SUM_LOW, 16'h0000);
    rdc(5'd30, 16'h0800);
    rdc(5'd30, 16'h0000);
    rdc(5'd20, 16'h0200);
    rdc(5'd0, 16'h0000);
  endtask

  task automatic t_gating;
    wr(qst_pkg::QST_SEL_MASK_LOW, 16'h7ffd);
    wr(qst_pkg::QST_SEL_MASK_MID, 16'h7ffd);
    wr(qst_pkg::QST_SEL_MASK_HIGH, 16'h000c);
    pulse_chan(1, 3);
    pulse_chan(15, 3);
    pulse_chan(29, 3);
    rd(qst_pkg::QST_SEL_SUM_LOW, 16'h0000);
    rd(qst_pkg::QST_SEL_SUM_MID, 16'h0000);
    rd(qst_pkg::QST_SEL_SUM_HIGH, 16'h0000);
    rdc(5'd1, 16'h0009);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // The whole run needs well under a thousand cycles.
  initial
  begin
    repeat (5000) @(posedge clk);
    errors++;
    stop_test;
  end

  initial
  begin
    errors = 0;
    checks = 0;
    rst = 1'b1;
    ques_cond = 12'h000;
    chan_cond = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_masks;
    t_events;
    t_map;
    t_cascade;
    t_gating;
    stop_test;
  end
endmodule // qst_status_tree_bench
